// [sps_pkg.sv]
// Constants and types for the setpoint profile sequencer.
// Assumes one scan strobe per instrument scan from surrounding logic.
//
// Summary of operation
// - Re-cycling reruns profile or batch phase
// - Repeat total zero cycles forever
// - Totals 1-255 give that many extra passes
// - Single phase ends before restarting segment one
// - Single phase: one ready scan, event outputs cleared
// - Elapsed time keeps counting across passes
// - Multi phase: end, then run at batch start
// - Four loops, segments 1-63, counts 1-999
// - Loop count is repetitions after first pass
// - Branch source completion jumps to target
// - Jump inside loop keeps loop counting
// - Jump outside loop exhausts that loop
// - Jump outside batch cancels re-cycling
// - Accelerated mode advances time times multiplier
// - Zero batch start or end means single phase
package sps_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int SEG_W        = 6;
  localparam int LOOP_N       = 4;
  localparam int LOOP_CNT_W   = 10;
  localparam int CYC_CNT_W    = 8;
  localparam int TIME_W       = 32;
  localparam int MULT_W       = 16;
  localparam int EVT_W        = 16;
  localparam logic [SEG_W-1:0] FIRST_SEG = 6'h01;
  localparam logic [SEG_W-1:0] NO_SEG    = 6'h00;
  localparam logic [CYC_CNT_W-1:0] CYC_FOREVER = 8'h00;
  localparam logic [TIME_W-1:0] ONE_SCAN = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [TIME_W-1:0]     RST_TIME = 32'h0000_0000;
  localparam logic [LOOP_CNT_W-1:0] RST_LOOP = 10'h000;
  localparam logic [CYC_CNT_W-1:0]  RST_CYC  = 8'h00;

  typedef enum logic [1:0] {
    ST_READY,
    ST_RUN,
    ST_END
  } sps_state_type;

endpackage

// [sps_time_step.sv]
// Per-scan profile time increment.
// Assumes multiplier is stable while the profile runs.
`timescale 1ns/1ns
module sps_time_step (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       fast_fwd,
  input  wire logic [sps_pkg::MULT_W-1:0] time_mult,
  output logic      [sps_pkg::TIME_W-1:0] step_q
);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_q <= sps_pkg::ONE_SCAN;
    end else if (ce) begin
      if (fast_fwd) begin
        step_q <= {{(sps_pkg::TIME_W-sps_pkg::MULT_W){1'b0}}, time_mult};
      end else begin
        step_q <= sps_pkg::ONE_SCAN;
      end
    end
  end

endmodule // sps_time_step

// [sps_sequencer.sv]
// Setpoint profile sequencer: segment order, loops, branch, re-cycling.
// Assumes seg_done pulses on the scan strobe when a segment completes;
// configuration is static while running.
`timescale 1ns/1ns
module sps_sequencer (
  input  wire logic                                        clk_sys,
  input  wire logic                                        rst,
  input  wire logic                                        ce,
  input  wire logic                                        scan,
  input  wire logic                                        start,
  input  wire logic                                        seg_done,
  input  wire logic [sps_pkg::SEG_W-1:0]                   last_seg,
  input  wire logic [sps_pkg::SEG_W-1:0]                   batch_first,
  input  wire logic [sps_pkg::SEG_W-1:0]                   batch_last,
  input  wire logic                                        cycle_en,
  input  wire logic [sps_pkg::CYC_CNT_W-1:0]               cycle_total,
  input  wire logic [sps_pkg::LOOP_N*sps_pkg::SEG_W-1:0]   loop_from,
  input  wire logic [sps_pkg::LOOP_N*sps_pkg::SEG_W-1:0]   loop_to,
  input  wire logic [sps_pkg::LOOP_N*sps_pkg::LOOP_CNT_W-1:0] loop_count,
  input  wire logic [sps_pkg::SEG_W-1:0]                   branch_source_step,
  input  wire logic [sps_pkg::SEG_W-1:0]                   branch_target_step,
  input  wire logic                                        fast_fwd,
  input  wire logic [sps_pkg::MULT_W-1:0]                  time_mult,
  input  wire logic [sps_pkg::EVT_W-1:0]                   seg_events,
  output logic      [sps_pkg::SEG_W-1:0]                   seg_q,
  output logic      [1:0]                                  state_q,
  output logic      [sps_pkg::TIME_W-1:0]                  elapsed_q,
  output logic      [sps_pkg::EVT_W-1:0]                   events_q,
  output logic      [sps_pkg::CYC_CNT_W-1:0]               cycles_done_q
);

  localparam int SW = sps_pkg::SEG_W;
  localparam int CW = sps_pkg::LOOP_CNT_W;

  sps_pkg::sps_state_type st_q;
  logic [CW-1:0]          left_q [sps_pkg::LOOP_N];
  logic [sps_pkg::LOOP_N-1:0] armed_q;
  logic                   cyc_kill_q;
  logic [sps_pkg::TIME_W-1:0] step;
  logic                   multi;
  logic                   do_branch;
  logic                   at_end;
  logic                   cyc_more;
  logic [sps_pkg::LOOP_N-1:0] loop_back;
  logic [SW-1:0]          next_seg;
  logic                   step_ev;

  function automatic logic in_range(input logic [SW-1:0] s,
                                    input logic [SW-1:0] lo,
                                    input logic [SW-1:0] hi);
    in_range = (s >= lo) && (s <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Time step
  // ----------------------------------------------------------------
  sps_time_step u_step (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .fast_fwd  (fast_fwd),
    .time_mult (time_mult),
    .step_q    (step)
  );

  // ----------------------------------------------------------------
  // Next segment decision
  // ----------------------------------------------------------------
  assign multi = (batch_first != sps_pkg::NO_SEG) &&
                 (batch_last != sps_pkg::NO_SEG);
  assign step_ev = ce && scan && (st_q == sps_pkg::ST_RUN) && seg_done;
  assign do_branch = (branch_source_step != sps_pkg::NO_SEG) &&
                     (seg_q == branch_source_step);
  assign cyc_more = cycle_en && !cyc_kill_q &&
                    ((cycle_total == sps_pkg::CYC_FOREVER) ||
                     (cycles_done_q < cycle_total));

  always_comb begin
    loop_back = '0;
    for (int i = 0; i < sps_pkg::LOOP_N; i++) begin
      loop_back[i] = armed_q[i] && (left_q[i] != sps_pkg::RST_LOOP) &&
                     (seg_q == loop_to[i*SW +: SW]);
    end
  end

  always_comb begin
    next_seg = seg_q + 6'h01;
    at_end = 1'b0;
    if (do_branch) begin
      next_seg = branch_target_step;
    end else if (|loop_back) begin
      next_seg = seg_q;
      for (int i = sps_pkg::LOOP_N - 1; i >= 0; i--) begin
        if (loop_back[i]) begin
          next_seg = loop_from[i*SW +: SW];
        end
      end
    end else if (multi && seg_q == batch_last && cyc_more) begin
      at_end = 1'b1;
    end else if (seg_q >= last_seg) begin
      at_end = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q  <= sps_pkg::ST_READY;
      seg_q <= sps_pkg::FIRST_SEG;
    end else if (ce) begin
      case (st_q)
        sps_pkg::ST_READY: begin
          if (start || (scan && cycles_done_q != '0)) begin
            st_q  <= sps_pkg::ST_RUN;
            seg_q <= sps_pkg::FIRST_SEG;
          end
        end
        sps_pkg::ST_RUN: begin
          if (step_ev) begin
            if (at_end) begin
              st_q <= sps_pkg::ST_END;
            end else begin
              seg_q <= next_seg;
            end
          end
        end
        sps_pkg::ST_END: begin
          if (start) begin
            st_q  <= sps_pkg::ST_RUN;
            seg_q <= sps_pkg::FIRST_SEG;
          end else if (scan && cyc_more) begin
            if (multi) begin
              st_q  <= sps_pkg::ST_RUN;
              seg_q <= batch_first;
            end else begin
              st_q <= sps_pkg::ST_READY;
            end
          end // else stay ended
        end
        default: st_q <= sps_pkg::ST_READY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Loop counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_q <= '0;
      for (int i = 0; i < sps_pkg::LOOP_N; i++) begin
        left_q[i] <= sps_pkg::RST_LOOP;
      end
    end else if (ce && step_ev) begin
      for (int i = 0; i < sps_pkg::LOOP_N; i++) begin
        if (do_branch && armed_q[i] && !in_range(branch_target_step,
            loop_from[i*SW +: SW], loop_to[i*SW +: SW])) begin
          left_q[i] <= sps_pkg::RST_LOOP;
        end else if (do_branch) begin
          left_q[i] <= left_q[i];
        end else if (loop_back[i]) begin
          left_q[i] <= left_q[i] - 10'h001;
        end else if (seg_q == loop_to[i*SW +: SW]) begin
          armed_q[i] <= 1'b0;
        end else if (!armed_q[i] && next_seg == loop_from[i*SW +: SW]) begin
          armed_q[i] <= 1'b1;
          left_q[i]  <= loop_count[i*CW +: CW];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Re-cycling count and cancel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cycles_done_q <= sps_pkg::RST_CYC;
      cyc_kill_q    <= 1'b0;
    end else if (ce) begin
      if (start && st_q != sps_pkg::ST_RUN) begin
        cycles_done_q <= sps_pkg::RST_CYC;
        cyc_kill_q    <= 1'b0;
      end else if (st_q == sps_pkg::ST_END && scan && cyc_more) begin
        if (cycles_done_q != 8'hff) begin
          cycles_done_q <= cycles_done_q + 8'h01;
        end
      end else if (step_ev && do_branch && multi &&
                   !in_range(branch_target_step, batch_first, batch_last)) begin
        cyc_kill_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Elapsed time and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      elapsed_q <= sps_pkg::RST_TIME;
    end else if (ce) begin
      if (start && st_q != sps_pkg::ST_RUN && cycles_done_q == '0) begin
        elapsed_q <= sps_pkg::RST_TIME;
      end else if (scan && st_q != sps_pkg::ST_END &&
                   (st_q == sps_pkg::ST_RUN || cycles_done_q != '0)) begin
        elapsed_q <= elapsed_q + step;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      events_q <= '0;
      state_q  <= 2'h0;
    end else if (ce) begin
      state_q <= st_q;
      if (st_q == sps_pkg::ST_READY) begin
        events_q <= '0;
      end else if (st_q == sps_pkg::ST_RUN) begin
        events_q <= seg_events;
      end
    end
  end

endmodule // sps_sequencer

// [sps_sequencer_assertions.sv]
// Port-level checks on the profile sequencer.
// Assumes scans come at least two clocks apart.
`timescale 1ns/1ns
module sps_checker (
  input wire logic                          clk_sys,
  input wire logic                          rst,
  input wire logic                          ce,
  input wire logic                          start,
  input wire logic                          scan,
  input wire logic                          cycle_en,
  input wire logic                          fast_fwd,
  input wire logic [sps_pkg::MULT_W-1:0]    time_mult,
  input wire logic [sps_pkg::SEG_W-1:0]     batch_first,
  input wire logic [sps_pkg::SEG_W-1:0]     batch_last,
  input wire logic [sps_pkg::SEG_W-1:0]     seg_q,
  input wire logic [1:0]                    state_q,
  input wire logic [sps_pkg::TIME_W-1:0]    elapsed_q,
  input wire logic [sps_pkg::EVT_W-1:0]     events_q,
  input wire logic [sps_pkg::CYC_CNT_W-1:0] cycles_done_q
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_recycle_ready;
    $past(state_q) == 2'h2 && state_q == 2'h0;
  endsequence
  sequence s_quiet_end;
    state_q == 2'h2 && !$past(start) && !$past(rst);
  endsequence
  sequence s_run_steady;
    state_q == 2'h1 && $past(state_q) == 2'h1;
  endsequence

  a_ready_clears: assert property (
    s_recycle_ready |-> events_q == '0) else $error("events kept");
  a_ready_leaves: assert property (
    s_recycle_ready and cycle_en |-> ##[1:6] state_q == 2'h1)
    else $error("ready too long");
  a_restart_first: assert property (
    $past(state_q) == 2'h0 && state_q == 2'h1 |-> seg_q == 6'h01)
    else $error("restart not at first segment");
  a_cycle_step: assert property (
    cycles_done_q > $past(cycles_done_q)
    |-> cycles_done_q == $past(cycles_done_q) + 8'h01)
    else $error("cycle count jumped");
  a_end_holds: assert property (
    s_quiet_end and !cycle_en |=> state_q == 2'h2) else $error("left end");
  a_multi_no_ready: assert property (
    s_quiet_end and batch_first != 6'h00 && batch_last != 6'h00
    |=> state_q != 2'h0) else $error("multi phase entered ready");
  a_elapsed_end: assert property (
    $past(state_q) == 2'h2 && state_q == 2'h2 && !$past(start)
    |-> $stable(elapsed_q))
    else $error("time moved in end");
  a_time_normal: assert property (
    s_run_steady and !fast_fwd && !$past(fast_fwd) && !$past(fast_fwd, 2)
    |-> elapsed_q - $past(elapsed_q) ==
        (($past(scan) && $past(ce)) ? 32'h0000_0001 : 32'h0000_0000))
    else $error("normal step wrong");
  a_time_fast: assert property (
    s_run_steady and fast_fwd && $past(fast_fwd) && $past(fast_fwd, 2)
    |-> elapsed_q - $past(elapsed_q) == (($past(scan) && $past(ce)) ?
        {16'h0000, $past(time_mult, 2)} : 32'h0000_0000))
    else $error("fast step wrong");
endmodule // sps_checker

bind sps_sequencer sps_checker u_sps_checker (.clk_sys, .rst, .ce, .start,
  .scan, .cycle_en, .fast_fwd, .time_mult, .batch_first, .batch_last,
  .seg_q, .state_q, .elapsed_q, .events_q, .cycles_done_q);

// [test_setpoint_profile_sequencer.sv]
// Self-checking bench for the profile sequencer.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
module test_setpoint_profile_sequencer;
  logic        clk_sys, rst, ce, scan, start, seg_done, cycle_en, fast_fwd;
  logic [5:0]  last_seg, batch_first, batch_last, seg_q, br_src, br_dst;
  logic [23:0] loop_from, loop_to;
  logic [39:0] loop_count;
  logic [7:0]  cycle_total, cycles_done_q;
  logic [15:0] time_mult, seg_events, events_q;
  logic [1:0]  state_q;
  logic [31:0] elapsed_q, e1;
  int          failures = 0, checks = 0, cyc = 0;

  sps_sequencer u_sps_sequencer (.clk_sys, .rst, .ce, .scan, .start,
    .seg_done, .last_seg, .batch_first, .batch_last, .cycle_en,
    .cycle_total, .loop_from, .loop_to, .loop_count,
    .branch_source_step(br_src), .branch_target_step(br_dst), .fast_fwd,
    .time_mult, .seg_events, .seg_q, .state_q, .elapsed_q, .events_q,
    .cycles_done_q);

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic pulse(input logic d);
    @(posedge clk_sys);
    scan <= 1'h1;
    seg_done <= d;
    @(posedge clk_sys);
    scan <= 1'h0;
    seg_done <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic go;
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    start <= 1'h1;
    @(posedge clk_sys);
    start <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic run_seq(input int n);
    repeat (n - 1) pulse(1'h1);
    chk("state", 2'h1, state_q);
    pulse(1'h1);
    chk("state", 2'h2, state_q);
  endtask
  task automatic cfg(input logic [5:0] l, bf, bl, input logic [7:0] t);
    last_seg <= l;
    batch_first <= bf;
    batch_last <= bl;
    cycle_total <= t;
    cycle_en <= 1'h1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_single;
    cfg(6'h02, 6'h00, 6'h00, 8'h01);
    seg_events <= 16'h00a5;
    go();
    run_seq(2);
    e1 = elapsed_q;
    pulse(1'h0);
    chk("state", 2'h0, state_q);
    chk("events", 16'h0000, events_q);
    pulse(1'h0);
    chk("seg", 6'h01, seg_q);
    chk("cycles", 8'h01, cycles_done_q);
    run_seq(2);
    chk("elapsed grew", 1'h1, elapsed_q > e1);
    pulse(1'h0);
    chk("state", 2'h2, state_q);
  endtask
  task automatic t_forever;
    cfg(6'h01, 6'h00, 6'h00, 8'h00);
    go();
    for (int i = 1; i < 4; i++) begin
      run_seq(1);
      pulse(1'h0);
      chk("state", 2'h0, state_q);
      pulse(1'h0);
      chk("cycles", i, cycles_done_q);
    end
  endtask
  task automatic t_multi;
    cfg(6'h03, 6'h02, 6'h02, 8'h01);
    go();
    run_seq(2);
    pulse(1'h0);
    chk("state", 2'h1, state_q);
    chk("seg", 6'h02, seg_q);
    run_seq(2);
    chk("seg", 6'h03, seg_q);
  endtask
  task automatic t_branch;
    cfg(6'h04, 6'h02, 6'h03, 8'h00);
    br_src <= 6'h02;
    br_dst <= 6'h04;
    go();
    run_seq(3);
    chk("seg", 6'h04, seg_q);
    pulse(1'h0);
    chk("state", 2'h2, state_q);
    br_src <= 6'h00;
  endtask
  task automatic t_loop;
    cfg(6'h04, 6'h00, 6'h00, 8'h00);
    loop_from <= {6'h02, 18'h0_0000};
    loop_to <= {6'h03, 18'h0_0000};
    loop_count <= {10'h002, 30'h0000_0000};
    go();
    cycle_en <= 1'h0;
    run_seq(8);
    chk("seg", 6'h04, seg_q);
    br_src <= 6'h02;
    br_dst <= 6'h03;
    go();
    run_seq(8);
    chk("seg", 6'h04, seg_q);
    br_src <= 6'h00;
    loop_count <= '0;
  endtask
  task automatic t_fast;
    cfg(6'h3f, 6'h00, 6'h00, 8'h00);
    time_mult <= 16'h0005;
    go();
    fast_fwd <= 1'h1;
    repeat (2) @(posedge clk_sys);
    e1 = elapsed_q;
    pulse(1'h0);
    chk("fast time", e1 + 32'h0000_0005, elapsed_q);
    fast_fwd <= 1'h0;
    repeat (2) @(posedge clk_sys);
    e1 = elapsed_q;
    pulse(1'h0);
    chk("normal time", e1 + 32'h0000_0001, elapsed_q);
    ce <= 1'h0;
    e1 = elapsed_q;
    pulse(1'h1);
    chk("held time", e1, elapsed_q);
    chk("held seg", 6'h01, seg_q);
    ce <= 1'h1;
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {scan, start, seg_done, cycle_en, fast_fwd, br_src, br_dst} = '0;
    {last_seg, batch_first, batch_last, cycle_total, time_mult} = '0;
    {loop_from, loop_to, loop_count, seg_events} = '0;
    ce = 1'h1;
    rst = 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    t_single();
    t_forever();
    t_multi();
    t_branch();
    t_loop();
    t_fast();
    end_sim();
  end
endmodule // test_setpoint_profile_sequencer
